// [design/acd_pkg.sv]
// Package for the audio clock divider configuration block: offsets, fields, resets and carriers.
package acd_pkg;

   // Printed register indices; byte address on the bus is four times the index.
   localparam logic [7:0] ACD_IDX_CONV    = 8'h1C;
   localparam logic [7:0] ACD_IDX_CP      = 8'h1D;
   localparam logic [7:0] ACD_IDX_OSR     = 8'h1E;
   localparam logic [7:0] ACD_IDX_BCLK    = 8'h20;
   localparam logic [7:0] ACD_IDX_LRCK    = 8'h21;
   localparam logic [7:0] ACD_IDX_MODE    = 8'h22;
   localparam logic [7:0] ACD_IDX_AUTOSET = 8'h25;

   // Bus widths and response codes.
   localparam int         ACD_ADDR_W      = 10;
   localparam logic [1:0] ACD_RESP_OKAY   = 2'h0;
   localparam logic [1:0] ACD_RESP_SLVERR = 2'h2;

   // Field positions inside the mode and autoset registers.
   localparam int ACD_I16_BIT         = 4;
   localparam int ACD_SPEED_LSB       = 0;
   localparam int ACD_AUTOSET_DIS_BIT = 1;

   // Values after reset.
   localparam logic [6:0] ACD_CONV_RST        = 7'h01;
   localparam logic [6:0] ACD_CP_RST          = 7'h01;
   localparam logic [6:0] ACD_OSR_RST         = 7'h01;
   localparam logic [6:0] ACD_BCLK_RST        = 7'h00;
   localparam logic [7:0] ACD_LRCK_RST        = 8'h00;
   localparam logic       ACD_I16_RST         = 1'b0;
   localparam logic [2:0] ACD_SPEED_RST       = 3'h4;
   localparam logic       ACD_AUTOSET_DIS_RST = 1'b0;

   // Legal sample-rate speed-mode codes.
   localparam logic [2:0] ACD_SPEED_48K = 3'h3;
   localparam logic [2:0] ACD_SPEED_96K = 3'h4;
   localparam logic [2:0] ACD_SPEED_32K = 3'h7;

   // Divider and speed settings that automatic setup may override.
   typedef struct packed {
      logic [6:0] converter_clock_divider;
      logic [6:0] charge_pump_clock_divider;
      logic [6:0] oversample_clock_divider;
      logic [2:0] sample_rate_speed_mode;
   } acd_clk_cfg_t;

   // Complete software-visible register state.
   typedef struct packed {
      acd_clk_cfg_t clk;
      logic [6:0]   master_bit_clock_divider;
      logic [7:0]   master_frame_clock_divider;
      logic         interpolation_16x_select;
      logic         autoset_disable;
   } acd_regs_t;

   localparam acd_regs_t ACD_REGS_RST = '{
      clk: '{converter_clock_divider: ACD_CONV_RST, charge_pump_clock_divider: ACD_CP_RST,
             oversample_clock_divider: ACD_OSR_RST, sample_rate_speed_mode: ACD_SPEED_RST},
      master_bit_clock_divider: ACD_BCLK_RST,
      master_frame_clock_divider: ACD_LRCK_RST,
      interpolation_16x_select: ACD_I16_RST,
      autoset_disable: ACD_AUTOSET_DIS_RST};

endpackage : acd_pkg

// [design/acd_clock_divider.sv]
// Clock divider configuration registers behind AXI4-Lite and the divider tick generators.
//
// Functional notes
// RL1 - Converter clock is source clock divided by seven-bit field plus one, 1 to 128.
// RL2 - Charge-pump clock is source clock divided by its field plus one, 1 to 128.
// RL3 - Oversampling clock is source clock divided by its field plus one, 1 to 128.
// RL4 - During automatic setup, programmed dividers and speed mode are replaced by internal values.
// RL5 - As serial master, bit clock is master clock divided by field plus one.
// RL6 - As serial master, frame clock is bit clock divided by eight-bit field plus one.
// RL7 - Interpolation select 0 gives eightfold, 1 gives sixteenfold; cleared at reset.
// RL8 - Speed mode codes 011, 100, 111 only; other codes are reserved.
// RL9 - Autoset disable bit 0 enables automatic setup; 1 means manual programming.
// RL10 - Reserved bits ignore writes and read back as zero.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module acd_clock_divider (
   // Clock and synchronous active-low reset.
   input  wire logic                        mclk,
   input  wire logic                        rst_n,
   // AXI4-Lite write address and data.
   input  wire logic [acd_pkg::ACD_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   // AXI4-Lite read.
   input  wire logic [acd_pkg::ACD_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   // Automatic setup engine and serial-port mode.
   input  wire acd_pkg::acd_clk_cfg_t       auto_cfg,
   input  wire logic                        serial_master_en,
   // Effective settings and divider ticks.
   output acd_pkg::acd_clk_cfg_t            clk_cfg_eff,
   output logic                             interp_16x,
   output logic                             autoset_active,
   output logic                             speed_reserved,
   output logic                             conv_tick,
   output logic                             cp_tick,
   output logic                             osr_tick,
   output logic                             bclk_tick,
   output logic                             lrck_tick
);
   import acd_pkg::*;

   // Byte address of a register index.
   function automatic logic [ACD_ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = {idx, 2'b00};
   endfunction

   // True when the address selects a mapped register.
   function automatic logic is_mapped(input logic [ACD_ADDR_W-1:0] a);
      is_mapped = (a == reg_addr(ACD_IDX_CONV)) || (a == reg_addr(ACD_IDX_CP)) ||
                  (a == reg_addr(ACD_IDX_OSR)) || (a == reg_addr(ACD_IDX_BCLK)) ||
                  (a == reg_addr(ACD_IDX_LRCK)) || (a == reg_addr(ACD_IDX_MODE)) ||
                  (a == reg_addr(ACD_IDX_AUTOSET));
   endfunction

   // Register image for a read; unlisted and reserved bits stay zero.
   function automatic logic [31:0] read_word(input acd_regs_t r, input logic [ACD_ADDR_W-1:0] a);
      read_word = 32'h0000_0000;
      if (a == reg_addr(ACD_IDX_CONV))
         read_word[6:0] = r.clk.converter_clock_divider;
      else if (a == reg_addr(ACD_IDX_CP))
         read_word[6:0] = r.clk.charge_pump_clock_divider;
      else if (a == reg_addr(ACD_IDX_OSR))
         read_word[6:0] = r.clk.oversample_clock_divider;
      else if (a == reg_addr(ACD_IDX_BCLK))
         read_word[6:0] = r.master_bit_clock_divider;
      else if (a == reg_addr(ACD_IDX_LRCK))
         read_word[7:0] = r.master_frame_clock_divider;
      else if (a == reg_addr(ACD_IDX_MODE)) begin
         read_word[ACD_I16_BIT] = r.interpolation_16x_select;
         read_word[ACD_SPEED_LSB +: 3] = r.clk.sample_rate_speed_mode;
      end else if (a == reg_addr(ACD_IDX_AUTOSET))
         read_word[ACD_AUTOSET_DIS_BIT] = r.autoset_disable;
   endfunction

   // Register state after a write of the low byte; reserved bits are dropped.
   function automatic acd_regs_t apply_write(input acd_regs_t r, input logic [ACD_ADDR_W-1:0] a,
                                             input logic [7:0] d);
      apply_write = r;
      if (a == reg_addr(ACD_IDX_CONV))
         apply_write.clk.converter_clock_divider = d[6:0]; // RL10
      else if (a == reg_addr(ACD_IDX_CP))
         apply_write.clk.charge_pump_clock_divider = d[6:0];
      else if (a == reg_addr(ACD_IDX_OSR))
         apply_write.clk.oversample_clock_divider = d[6:0];
      else if (a == reg_addr(ACD_IDX_BCLK))
         apply_write.master_bit_clock_divider = d[6:0];
      else if (a == reg_addr(ACD_IDX_LRCK))
         apply_write.master_frame_clock_divider = d;
      else if (a == reg_addr(ACD_IDX_MODE)) begin
         apply_write.interpolation_16x_select = d[ACD_I16_BIT]; // RL7
         apply_write.clk.sample_rate_speed_mode = d[ACD_SPEED_LSB +: 3];
      end else if (a == reg_addr(ACD_IDX_AUTOSET))
         apply_write.autoset_disable = d[ACD_AUTOSET_DIS_BIT]; // RL9
   endfunction

   // Divider counter step: reload with the divide code at zero, else count down.
   function automatic logic [7:0] div_next(input logic [7:0] cnt, input logic [7:0] div);
      div_next = (cnt == 8'h00) ? div : cnt - 8'h01;
   endfunction

   acd_regs_t             regs_q,     regs_d;
   logic                  aw_got_q,   aw_got_d;
   logic                  w_got_q,    w_got_d;
   logic [ACD_ADDR_W-1:0] awaddr_q,   awaddr_d;
   logic [7:0]            wbyte_q,    wbyte_d;
   logic                  wen_q,      wen_d;
   logic                  bvalid_q,   bvalid_d;
   logic [1:0]            bresp_q,    bresp_d;
   logic                  rvalid_q,   rvalid_d;
   logic [1:0]            rresp_q,    rresp_d;
   logic [31:0]           rdata_q,    rdata_d;

   // Handshake readies: one write and one read in flight at a time.
   assign s_axi_awready = !aw_got_q && !bvalid_q;
   assign s_axi_wready  = !w_got_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;

   // Bus slave: address and data taken in either order, write commits when both are held.
   always_comb begin
      regs_d   = regs_q;
      aw_got_d = aw_got_q;
      w_got_d  = w_got_q;
      awaddr_d = awaddr_q;
      wbyte_d  = wbyte_q;
      wen_d    = wen_q;
      bvalid_d = bvalid_q && !s_axi_bready;
      bresp_d  = bresp_q;
      rvalid_d = rvalid_q && !s_axi_rready;
      rresp_d  = rresp_q;
      rdata_d  = rdata_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_got_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_got_d = 1'b1;
         wbyte_d = s_axi_wdata[7:0];
         wen_d   = s_axi_wstrb[0];
      end
      if (aw_got_d && w_got_d) begin
         aw_got_d = 1'b0;
         w_got_d  = 1'b0;
         bvalid_d = 1'b1;
         bresp_d  = is_mapped(awaddr_d) ? ACD_RESP_OKAY : ACD_RESP_SLVERR;
         if (wen_d && is_mapped(awaddr_d))
            regs_d = apply_write(regs_q, awaddr_d, wbyte_d);
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rresp_d  = is_mapped(s_axi_araddr) ? ACD_RESP_OKAY : ACD_RESP_SLVERR;
         rdata_d  = read_word(regs_q, s_axi_araddr); // RL10
      end
   end

   // Bus slave and register state.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         regs_q   <= ACD_REGS_RST; // RL7
         aw_got_q <= 1'b0;
         w_got_q  <= 1'b0;
         awaddr_q <= '0;
         wbyte_q  <= 8'h00;
         wen_q    <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q  <= ACD_RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q  <= ACD_RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
      end else begin
         regs_q   <= regs_d;
         aw_got_q <= aw_got_d;
         w_got_q  <= w_got_d;
         awaddr_q <= awaddr_d;
         wbyte_q  <= wbyte_d;
         wen_q    <= wen_d;
         bvalid_q <= bvalid_d;
         bresp_q  <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q  <= rresp_d;
         rdata_q  <= rdata_d;
      end
   end

   acd_clk_cfg_t eff_q,       eff_d;
   logic         i16_q,       i16_d;
   logic         auto_q,      auto_d;
   logic         spd_rsv_q,   spd_rsv_d;
   logic [7:0]   conv_cnt_q,  conv_cnt_d;
   logic [7:0]   cp_cnt_q,    cp_cnt_d;
   logic [7:0]   osr_cnt_q,   osr_cnt_d;
   logic [7:0]   bclk_cnt_q,  bclk_cnt_d;
   logic [7:0]   lrck_cnt_q,  lrck_cnt_d;
   logic [4:0]   tick_q,      tick_d;

   assign clk_cfg_eff    = eff_q;
   assign interp_16x     = i16_q;
   assign autoset_active = auto_q;
   assign speed_reserved = spd_rsv_q;
   assign conv_tick      = tick_q[0];
   assign cp_tick        = tick_q[1];
   assign osr_tick       = tick_q[2];
   assign bclk_tick      = tick_q[3];
   assign lrck_tick      = tick_q[4];

   // Effective settings and divider counters; a new divide code takes hold at the next reload.
   always_comb begin
      eff_d     = regs_q.autoset_disable ? regs_q.clk : auto_cfg; // RL4
      auto_d    = !regs_q.autoset_disable; // RL9
      i16_d     = regs_q.interpolation_16x_select; // RL7
      spd_rsv_d = !((eff_q.sample_rate_speed_mode == ACD_SPEED_48K) || // RL8
                    (eff_q.sample_rate_speed_mode == ACD_SPEED_96K) ||
                    (eff_q.sample_rate_speed_mode == ACD_SPEED_32K));
      conv_cnt_d = div_next(conv_cnt_q, {1'b0, eff_q.converter_clock_divider}); // RL1
      cp_cnt_d   = div_next(cp_cnt_q, {1'b0, eff_q.charge_pump_clock_divider}); // RL2
      osr_cnt_d  = div_next(osr_cnt_q, {1'b0, eff_q.oversample_clock_divider}); // RL3
      bclk_cnt_d = 8'h00;
      lrck_cnt_d = 8'h00;
      if (serial_master_en) begin
         bclk_cnt_d = div_next(bclk_cnt_q, {1'b0, regs_q.master_bit_clock_divider}); // RL5
         lrck_cnt_d = tick_q[3] ? div_next(lrck_cnt_q, regs_q.master_frame_clock_divider) : lrck_cnt_q; // RL6
      end
      tick_d[0] = (conv_cnt_d == 8'h00);
      tick_d[1] = (cp_cnt_d == 8'h00);
      tick_d[2] = (osr_cnt_d == 8'h00);
      tick_d[3] = serial_master_en && (bclk_cnt_d == 8'h00);
      tick_d[4] = tick_d[3] && (lrck_cnt_d == 8'h00);
   end

   // Effective settings and divider counter registers.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         eff_q      <= ACD_REGS_RST.clk;
         i16_q      <= ACD_I16_RST;
         auto_q     <= 1'b0;
         spd_rsv_q  <= 1'b0;
         conv_cnt_q <= 8'h00;
         cp_cnt_q   <= 8'h00;
         osr_cnt_q  <= 8'h00;
         bclk_cnt_q <= 8'h00;
         lrck_cnt_q <= 8'h00;
         tick_q     <= 5'h00;
      end else begin
         eff_q      <= eff_d;
         i16_q      <= i16_d;
         auto_q     <= auto_d;
         spd_rsv_q  <= spd_rsv_d;
         conv_cnt_q <= conv_cnt_d;
         cp_cnt_q   <= cp_cnt_d;
         osr_cnt_q  <= osr_cnt_d;
         bclk_cnt_q <= bclk_cnt_d;
         lrck_cnt_q <= lrck_cnt_d;
         tick_q     <= tick_d;
      end
   end

   // A tick followed by one quiet cycle and another tick: divide by two.
   sequence s_div2(t);
      !t ##1 t;
   endsequence

   property p_conv_div1;
      @(posedge mclk) disable iff (!rst_n) (conv_tick && eff_q.converter_clock_divider == 7'h00) |=> conv_tick;
   endproperty
   a_conv_div1: assert property (p_conv_div1) else $error("converter divide by 1 broken"); // RL1
   property p_conv_div2;
      @(posedge mclk) disable iff (!rst_n)
         (conv_tick && eff_q.converter_clock_divider == 7'h01) ##1 (eff_q.converter_clock_divider == 7'h01)
         |-> s_div2(conv_tick);
   endproperty
   a_conv_div2: assert property (p_conv_div2) else $error("converter divide by 2 broken"); // RL1

   property p_cp_reload;
      @(posedge mclk) disable iff (!rst_n) cp_tick |=> (cp_cnt_q == {1'b0, $past(eff_q.charge_pump_clock_divider)});
   endproperty
   a_cp_reload: assert property (p_cp_reload) else $error("charge pump divider reload wrong"); // RL2
   property p_osr_div2;
      @(posedge mclk) disable iff (!rst_n)
         (osr_tick && eff_q.oversample_clock_divider == 7'h01) ##1 (eff_q.oversample_clock_divider == 7'h01)
         |-> s_div2(osr_tick);
   endproperty
   a_osr_div2: assert property (p_osr_div2) else $error("oversample divide by 2 broken"); // RL3

   // The reset-release edge is checked too: the outputs already carry the automatic values one cycle later.
   property p_autoset_override;
      @(posedge mclk) disable iff (!rst_n)
         (rst_n && !regs_q.autoset_disable) |=> (eff_q == $past(auto_cfg) && autoset_active);
   endproperty
   a_autoset_override: assert property (p_autoset_override) else $error("autoset did not override"); // RL4
   property p_manual_cfg;
      @(posedge mclk) disable iff (!rst_n) regs_q.autoset_disable |=> (eff_q == $past(regs_q.clk) && !autoset_active);
   endproperty
   a_manual_cfg: assert property (p_manual_cfg) else $error("manual settings not applied"); // RL9

   property p_bclk_master_only;
      @(posedge mclk) disable iff (!rst_n) !$past(serial_master_en) |-> !bclk_tick;
   endproperty
   a_bclk_master_only: assert property (p_bclk_master_only) else $error("bit clock outside master mode"); // RL5
   property p_lrck_on_bclk;
      @(posedge mclk) disable iff (!rst_n) lrck_tick |-> bclk_tick;
   endproperty
   a_lrck_on_bclk: assert property (p_lrck_on_bclk) else $error("frame tick without bit tick"); // RL6

   property p_interp_follow;
      @(posedge mclk) disable iff (!rst_n) ##1 (interp_16x == $past(regs_q.interpolation_16x_select));
   endproperty
   a_interp_follow: assert property (p_interp_follow) else $error("interpolation select mismatch"); // RL7
   property p_speed_flag;
      @(posedge mclk) disable iff (!rst_n) (eff_q.sample_rate_speed_mode == ACD_SPEED_96K) |=> !speed_reserved;
   endproperty
   a_speed_flag: assert property (p_speed_flag) else $error("legal speed flagged reserved"); // RL8
   property p_rsvd_zero;
      @(posedge mclk) disable iff (!rst_n) s_axi_rvalid |-> (s_axi_rdata[31:8] == 24'h000000);
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read bits not zero"); // RL10

endmodule : acd_clock_divider

`default_nettype wire

// [design/acd_unused_placeholder_never.sv]
// Empty by intent; holds no logic.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [testbench/acd_clock_divider_bench.sv]
// Self-checking testbench for the clock divider configuration registers and their tick outputs.
`timescale 1ns/1ps
`default_nettype none

module acd_clock_divider_bench;
   import acd_pkg::*;

   logic                  mclk;
   logic                  rst_n;
   logic [ACD_ADDR_W-1:0] s_axi_awaddr;
   logic                  s_axi_awvalid;
   logic                  s_axi_awready;
   logic [31:0]           s_axi_wdata;
   logic [3:0]            s_axi_wstrb;
   logic                  s_axi_wvalid;
   logic                  s_axi_wready;
   logic [1:0]            s_axi_bresp;
   logic                  s_axi_bvalid;
   logic                  s_axi_bready;
   logic [ACD_ADDR_W-1:0] s_axi_araddr;
   logic                  s_axi_arvalid;
   logic                  s_axi_arready;
   logic [31:0]           s_axi_rdata;
   logic [1:0]            s_axi_rresp;
   logic                  s_axi_rvalid;
   logic                  s_axi_rready;
   acd_clk_cfg_t          auto_cfg;
   logic                  serial_master_en;
   acd_clk_cfg_t          clk_cfg_eff;
   logic                  interp_16x;
   logic                  autoset_active;
   logic                  speed_reserved;
   logic [4:0]            tk;
   int                    err_count;
   int                    samples_checked;
   logic [31:0]           seed_v;
   logic [31:0]           sh [6];
   logic [7:0]            idx [6] = '{ACD_IDX_CONV, ACD_IDX_CP, ACD_IDX_OSR, ACD_IDX_BCLK, ACD_IDX_LRCK, ACD_IDX_MODE};
   logic [31:0]           msk [6] = '{32'h7F, 32'h7F, 32'h7F, 32'h7F, 32'hFF, 32'h17};

   acd_clock_divider dut (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .auto_cfg(auto_cfg), .serial_master_en(serial_master_en), .clk_cfg_eff(clk_cfg_eff),
      .interp_16x(interp_16x), .autoset_active(autoset_active), .speed_reserved(speed_reserved),
      .conv_tick(tk[0]), .cp_tick(tk[1]), .osr_tick(tk[2]), .bclk_tick(tk[3]), .lrck_tick(tk[4]));

   // Free-running master clock of 100 ns period.
   initial mclk = 1'b0;
   always #50 mclk = ~mclk;

   // Steps the bench's pseudo-random source.
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected speed flag: only three codes are legal.
   function automatic logic rsv_exp(input logic [2:0] c);
      return !(c == 3'h3 || c == 3'h4 || c == 3'h7);
   endfunction

   // Expected effective settings from the shadow copy or the automatic values.
   function automatic acd_clk_cfg_t eff_exp(input logic a);
      return a ? auto_cfg : acd_clk_cfg_t'{sh[0][6:0], sh[1][6:0], sh[2][6:0], sh[5][2:0]};
   endfunction

   // Compares a value and counts the result.
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   // Compares a bus response code.
   task automatic chk_rsp(input logic [1:0] g, input logic [1:0] e, input string m);
      chk({30'h0, g}, {30'h0, e}, m);
   endtask

   // One bus write; waits for the response without assuming its latency.
   task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      @(posedge mclk);
      s_axi_awaddr  <= {i, 2'b00};
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   // One bus read; waits for the data without assuming its latency.
   task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk);
      s_axi_araddr  <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // Interval in clocks between ticks, measured after a reload so a new divide code has taken hold.
   task automatic per(input int k, output int p);
      for (int j = 0; j < 3; j++) begin
         p = 0;
         do begin
            @(posedge mclk);
            p++;
         end while (tk[k] !== 1'b1 && p < 1000);
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Watchdog sized well above the expected run of some 2000 clocks.
   initial begin
      repeat (60000) @(posedge mclk);
      err_count++;
      complete_run();
   end

   // Main sequence.
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      int          p;
      int          dv [4];
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready, auto_cfg, serial_master_en} = '0;
      err_count = 0;
      samples_checked = 0;
      seed_v = 32'h0000_0029;
      rst_n = 1'b0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      sh = '{{25'h0, ACD_CONV_RST}, {25'h0, ACD_CP_RST}, {25'h0, ACD_OSR_RST}, {25'h0, ACD_BCLK_RST},
             {24'h0, ACD_LRCK_RST}, {27'h0, ACD_I16_RST, 1'b0, ACD_SPEED_RST}};
      for (int k = 0; k < 6; k++) begin
         rd(idx[k], d, r);
         chk(d, sh[k], "reset value");
      end
      rd(ACD_IDX_AUTOSET, d, r);
      chk(d, 32'h0, "autoset reset");
      chk(interp_16x, 1'b0, "interp reset");
      chk(autoset_active, 1'b1, "autoset on");
      $display("test reset done");
      wr(8'hFF, 32'h0000_00FF, 4'hF, r);
      chk_rsp(r, ACD_RESP_SLVERR, "unmapped write");
      rd(8'hFF, d, r);
      chk_rsp(r, ACD_RESP_SLVERR, "unmapped read");
      chk(d, 32'h0, "unmapped data");
      wr(ACD_IDX_LRCK, 32'h5A, 4'h0, r);
      chk_rsp(r, ACD_RESP_OKAY, "strobe off resp");
      rd(ACD_IDX_LRCK, d, r);
      chk(d, sh[4], "strobe off");
      $display("test unmapped done");
      for (int n = 0; n < 4; n++) begin
         for (int k = 0; k < 6; k++) begin
            seed_v = lfsr_next(seed_v);
            d = (n == 0) ? 32'hFFFF_FFFF : seed_v;
            wr(idx[k], d, 4'hF, r);
            chk_rsp(r, ACD_RESP_OKAY, "write resp");
            sh[k] = d & msk[k];
            rd(idx[k], d, r);
            chk(d, sh[k], "readback");
         end
      end
      $display("test readback done");
      seed_v = lfsr_next(seed_v);
      auto_cfg <= seed_v[23:0];
      repeat (4) @(posedge mclk);
      chk(clk_cfg_eff, eff_exp(1'b1), "auto override");
      wr(ACD_IDX_AUTOSET, 32'h2, 4'hF, r);
      seed_v = lfsr_next(seed_v);
      auto_cfg <= seed_v[23:0];
      repeat (4) @(posedge mclk);
      chk(autoset_active, 1'b0, "autoset off");
      chk(clk_cfg_eff, eff_exp(1'b0), "manual settings");
      $display("test autoset done");
      seed_v = lfsr_next(seed_v);
      dv = '{0, 127, 5, int'(seed_v[6:0])};
      for (int n = 0; n < 4; n++) begin
         for (int k = 0; k < 3; k++) begin
            wr(idx[k], dv[n], 4'hF, r);
         end
         per(0, p);
         chk(p, dv[n] + 1, "converter period");
         per(1, p);
         chk(p, dv[n] + 1, "charge pump period");
         per(2, p);
         chk(p, dv[n] + 1, "oversample period");
      end
      $display("test dividers done");
      serial_master_en <= 1'b1;
      dv = '{2, 3, 0, 0};
      wr(ACD_IDX_BCLK, dv[0], 4'hF, r);
      wr(ACD_IDX_LRCK, dv[1], 4'hF, r);
      per(3, p);
      chk(p, dv[0] + 1, "bit clock period");
      per(4, p);
      chk(p, (dv[0] + 1) * (dv[1] + 1), "frame period");
      chk(tk[3], 1'b1, "frame on bit tick");
      serial_master_en <= 1'b0;
      repeat (3) @(posedge mclk);
      p = 0;
      repeat (200) begin
         @(posedge mclk);
         if (tk[4:3] !== 2'b00) p++;
      end
      chk(p, 0, "no ticks as slave");
      $display("test serial master done");
      for (int c = 0; c < 8; c++) begin
         wr(ACD_IDX_MODE, {27'h0, c[0], 1'b0, c[2:0]}, 4'hF, r);
         repeat (4) @(posedge mclk);
         chk(interp_16x, c[0], "interpolation");
         chk(speed_reserved, rsv_exp(c[2:0]), "speed flag");
         chk(clk_cfg_eff.sample_rate_speed_mode, c[2:0], "speed code");
      end
      $display("test speed modes done");
      rst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      rd(ACD_IDX_MODE, d, r);
      chk(d, {27'h0, ACD_I16_RST, 1'b0, ACD_SPEED_RST}, "mode after reset");
      rd(ACD_IDX_AUTOSET, d, r);
      chk(d, 32'h0, "autoset after reset");
      chk(interp_16x, ACD_I16_RST, "interp after reset");
      chk(autoset_active, 1'b1, "autoset on after reset");
      $display("test second reset done");
      complete_run();
   end

endmodule // acd_clock_divider_bench

`default_nettype wire
